/* rtl/epc_event_pulse_counter.sv */
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module epc_event_pulse_counter
	import epc_pkg::*;
(
	// clock, reset, freeze
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	// pins
	input wire logic event_input_pin,
	input wire logic count_direction_pin,
	input wire logic sub_clk,
	// cpu side
	input wire logic cpu_irq_mask,
	output logic irq_out
);

	// ==========================================================
	// registers
	logic [7:0] timer_mode_reg;
	logic [7:0] reload_value_reg;
	logic [7:0] event_counter_value;
	logic [1:0] pin_function_select;
	logic counter_wrap_flag;
	logic counter_irq_enable;
	logic [7:0] rdata_reg;
	logic [SYS_PRE_W-1:0] sys_pre_reg;
	logic [SUB_PRE_W-1:0] sub_pre_reg;
	logic sub_prev_reg;
	logic ev_meta_reg;
	logic ev_sync_reg;
	logic ev_prev_reg;

	logic wr_mode;
	logic wr_count;
	logic wr_pinsel;
	logic wr_clr;
	logic wr_en_reg;
	logic [3:0] clk_sel;
	logic [1:0] dir_field;
	logic ev_level;
	logic dir_level;
	logic sub_rise;
	logic ev_rise;
	logic ev_fall;
	logic tick;
	logic count_down;
	logic wrap;
	logic [7:0] count_next;
	epc_src_t src;
	int sub_log;

	// true when the low n bits of a prescaler are all ones
	function automatic logic pre_done(input logic [12:0] pre, input int n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < 13; i++)
		begin
			if (i < n)
				r = r & pre[i];
		end
		return r;
	endfunction

	assign wr_mode = wr_en && (addr == ADDR_MODE);
	assign wr_count = wr_en && (addr == ADDR_COUNT);
	assign wr_pinsel = wr_en && (addr == ADDR_PINSEL);
	assign wr_clr = wr_en && (addr == ADDR_IRQ_CLR);
	assign wr_en_reg = wr_en && (addr == ADDR_IRQ_EN);
	assign clk_sel = timer_mode_reg[MODE_CLK_HI:0];
	assign dir_field = timer_mode_reg[MODE_DIR_HI:MODE_DIR_LO];

	// ==========================================================
	// pin gating and synchronisers
	// unrouted pins read as low: no events, up-counting
	assign ev_level = event_input_pin & pin_function_select[PINSEL_EVENT_BIT];
	assign dir_level = count_direction_pin & pin_function_select[PINSEL_DIR_BIT];

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ev_meta_reg <= 1'b0;
			ev_sync_reg <= 1'b0;
			ev_prev_reg <= 1'b0;
		end
		else if (ce)
		begin
			ev_meta_reg <= ev_level;
			ev_sync_reg <= ev_meta_reg;
			ev_prev_reg <= ev_sync_reg;
		end
	end

	// edges taken only from the second stage, one count per edge
	assign ev_rise = ev_sync_reg & ~ev_prev_reg;
	assign ev_fall = ~ev_sync_reg & ev_prev_reg;

	// ==========================================================
	// prescalers
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			sys_pre_reg <= '0;
			sub_pre_reg <= '0;
			sub_prev_reg <= 1'b0;
		end
		else if (ce)
		begin
			sys_pre_reg <= sys_pre_reg + 1'b1;
			sub_prev_reg <= sub_clk;
			if (sub_rise)
				sub_pre_reg <= sub_pre_reg + 1'b1;
		end
	end

	// sub-clock is far slower than clk_sys, so edges are seen directly
	assign sub_rise = sub_clk & ~sub_prev_reg;

	// ==========================================================
	// source select
	always_comb
	begin
		src = EPC_SRC_SYS;
		sub_log = LOG_4;
		tick = 1'b0;
		case (clk_sel)
			CS_EXT_RISE:
			begin
				src = EPC_SRC_EXT;
				tick = ev_rise;
			end
			CS_EXT_FALL:
			begin
				src = EPC_SRC_EXT;
				tick = ev_fall;
			end
			CS_SUB_1024:
			begin
				src = EPC_SRC_SUB;
				sub_log = LOG_1024;
			end
			CS_SUB_256:
			begin
				src = EPC_SRC_SUB;
				sub_log = LOG_256;
			end
			CS_SUB_4:
			begin
				src = EPC_SRC_SUB;
				sub_log = LOG_4;
			end
			CS_SYS_4:
				tick = pre_done(sys_pre_reg, LOG_4);
			default:
			begin
				// remaining codes decode on the low three bits
				case (clk_sel[2:0])
					3'h0: tick = pre_done(sys_pre_reg, LOG_8192);
					3'h1: tick = pre_done(sys_pre_reg, LOG_2048);
					3'h2: tick = pre_done(sys_pre_reg, LOG_512);
					3'h3: tick = pre_done(sys_pre_reg, LOG_64);
					3'h4: tick = pre_done(sys_pre_reg, LOG_16);
					default: tick = 1'b0;
				endcase
			end
		endcase
		// one prescaler compare serves all three sub-clock divisors
		if (src == EPC_SRC_SUB)
			tick = sub_rise && pre_done({3'h0, sub_pre_reg}, sub_log);
	end

	// ==========================================================
	// direction and next count
	always_comb
	begin
		case (dir_field)
			DIR_UP: count_down = 1'b0;
			DIR_DOWN: count_down = 1'b1;
			default: count_down = dir_level;
		endcase
	end

	always_comb
	begin
		wrap = 1'b0;
		count_next = event_counter_value;
		if (tick)
		begin
			if (count_down)
			begin
				wrap = (event_counter_value == COUNT_RESET);
				count_next = event_counter_value - 8'h01;
			end
			else
			begin
				wrap = (event_counter_value == COUNT_MAX);
				count_next = event_counter_value + 8'h01;
			end
			if (wrap && timer_mode_reg[MODE_AUTORELOAD_BIT])
				count_next = reload_value_reg;
		end
	end

	// ==========================================================
	// counter and reload
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			event_counter_value <= COUNT_RESET;
			reload_value_reg <= RELOAD_RESET;
		end
		else if (ce)
		begin
			// a reload write also presets the counter
			if (wr_count)
			begin
				reload_value_reg <= wdata;
				event_counter_value <= wdata;
			end
			else
				event_counter_value <= count_next;
		end
	end

	// ==========================================================
	// mode and pin function registers
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_mode_reg <= MODE_RESET;
			pin_function_select <= 2'h0;
		end
		else if (ce)
		begin
			if (wr_mode)
				timer_mode_reg <= wdata | MODE_FIXED_ONES;
			if (wr_pinsel)
				pin_function_select <= wdata[1:0];
		end
	end

	// ==========================================================
	// interrupt
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			counter_wrap_flag <= 1'b0;
			counter_irq_enable <= 1'b0;
		end
		else if (ce)
		begin
			// a wrap in the clear cycle wins
			if (wrap)
				counter_wrap_flag <= 1'b1;
			else if (wr_clr && wdata[IRQ_WRAP_BIT])
				counter_wrap_flag <= 1'b0;
			if (wr_en_reg)
				counter_irq_enable <= wdata[IRQ_WRAP_BIT];
		end
	end

	assign irq_out = counter_wrap_flag & counter_irq_enable & ~cpu_irq_mask;

	// ==========================================================
	// read port
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			rdata_reg <= 8'h00;
		else if (ce)
		begin
			// zero between reads, so a stale value never passes for an answer
			rdata_reg <= 8'h00;
			if (rd_en)
			begin
				case (addr)
					ADDR_MODE: rdata_reg <= timer_mode_reg;
					ADDR_COUNT: rdata_reg <= event_counter_value;
					ADDR_PINSEL: rdata_reg <= {6'h00, pin_function_select};
					ADDR_IRQ_STAT: rdata_reg <= {7'h00, counter_wrap_flag};
					ADDR_IRQ_EN: rdata_reg <= {7'h00, counter_irq_enable};
					default: rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	assign rdata = rdata_reg;

endmodule // epc_event_pulse_counter

/* rtl/epc_pkg.sv */
// What this block does
// - mode register is 8-bit read/write, resets to 0x10.
// - mode register picks pin-controlled direction or fixed up/down counting.
// - 8-bit count value, read/write (a write also loads the reload value), steps by one per selected tick.
// - ten sources: six system-clock divisors, three sub-clock divisors, event pin.
// - wrap flag sets on counter overflow, marking a pending interrupt.
// - interrupt only when flag set, enable set, cpu mask clear.
// - from zero, 256 rising event edges overflow and raise interrupt.
// - direction pin held low under hardware control means up-counting.
// - software-written reload value reloads counter on overflow.
// - external source advances count once per detected event edge.
// - event and direction pins reach counter only when pin function enabled.
// - direction field 00 up, 01 down, 1x pin (high down).
// - clock select 1111 counts rising edges, 0111 falling edges.
// - auto-reload mode reloads from reload register on overflow or underflow.
// - cpu reads count at any time without disturbing counting.
package epc_pkg;
	// ==========================================================
	// register map, byte addresses
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_PINSEL = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
	// ==========================================================
	// fields and reset values
	localparam logic [7:0] MODE_RESET = 8'h10;
	localparam logic [7:0] MODE_FIXED_ONES = 8'h10;
	localparam int MODE_AUTORELOAD_BIT = 7;
	localparam int MODE_DIR_HI = 6;
	localparam int MODE_DIR_LO = 5;
	localparam int MODE_CLK_HI = 3;
	localparam int PINSEL_EVENT_BIT = 0;
	localparam int PINSEL_DIR_BIT = 1;
	localparam int IRQ_WRAP_BIT = 0;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [1:0] DIR_UP = 2'h0;
	localparam logic [1:0] DIR_DOWN = 2'h1;
	// ==========================================================
	// clock select codes
	localparam logic [3:0] CS_EXT_FALL = 4'h7;
	localparam logic [3:0] CS_EXT_RISE = 4'hf;
	localparam logic [3:0] CS_SUB_1024 = 4'h6;
	localparam logic [3:0] CS_SUB_256 = 4'hd;
	localparam logic [3:0] CS_SUB_4 = 4'he;
	localparam logic [3:0] CS_SYS_4 = 4'h5;
	// prescaler widths are log2 of the divisors
	localparam int SYS_PRE_W = 13;
	localparam int SUB_PRE_W = 10;
	localparam int LOG_8192 = 13;
	localparam int LOG_2048 = 11;
	localparam int LOG_512 = 9;
	localparam int LOG_64 = 6;
	localparam int LOG_16 = 4;
	localparam int LOG_1024 = 10;
	localparam int LOG_256 = 8;
	localparam int LOG_4 = 2;
	typedef enum logic [1:0] {EPC_SRC_SYS, EPC_SRC_SUB, EPC_SRC_EXT} epc_src_t;
endpackage

/* tb/epc_event_pulse_counter_monitor.sv */
`timescale 1ns/10ps
module epc_event_pulse_counter_monitor
	import epc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	// pins and interrupt
	input wire logic event_input_pin,
	input wire logic count_direction_pin,
	input wire logic sub_clk,
	input wire logic cpu_irq_mask,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// ==========================================================
	// bus steps
	sequence s_wr(logic [7:0] a);
		wr_en && ce && addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		rd_en && ce && addr == a;
	endsequence
	// ==========================================================
	// checks
	a_irq_mask_gate: assert property (cpu_irq_mask |-> !irq_out)
		else $error("irq high while masked");
	a_stat_irq_flag: assert property (s_rd(ADDR_IRQ_STAT) ##0 irq_out |=> rdata[0])
		else $error("irq high without wrap flag");
	a_en_irq_bit: assert property (s_rd(ADDR_IRQ_EN) ##0 irq_out |=> rdata[0])
		else $error("irq high without enable");
	a_mode_bit_four: assert property (s_rd(ADDR_MODE) |=> rdata[4])
		else $error("mode bit 4 read as 0");
	a_mode_write_read: assert property (s_wr(ADDR_MODE) ##2 s_rd(ADDR_MODE)
		|=> rdata == ($past(wdata, 3) | MODE_FIXED_ONES))
		else $error("mode readback wrong");
	a_pinsel_write_read: assert property (s_wr(ADDR_PINSEL) ##2 s_rd(ADDR_PINSEL)
		|=> rdata[1:0] == $past(wdata[1:0], 3))
		else $error("pin select readback wrong");
	a_rdata_idle_zero: assert property ($past(ce) && !$past(rd_en) |-> rdata == 8'h00)
		else $error("read data not zero when idle");
	a_unmapped_zero: assert property (rd_en && ce && addr > ADDR_IRQ_EN |=> rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // epc_event_pulse_counter_monitor

bind epc_event_pulse_counter epc_event_pulse_counter_monitor u_mon (.clk_sys(clk_sys),
	.resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
	.rdata(rdata), .event_input_pin(event_input_pin), .count_direction_pin(count_direction_pin),
	.sub_clk(sub_clk), .cpu_irq_mask(cpu_irq_mask), .irq_out(irq_out));

/* tb/epc_pulse_src.sv */
`timescale 1ns/10ps
module epc_pulse_src (
	// clock
	input wire logic clk_sys,
	// event line
	output logic pin
);
	initial pin = 1'b0;
	// half of two or more keeps each level long enough for the synchroniser
	task automatic pulses(input int n, input int half);
		repeat (n)
		begin
			@(posedge clk_sys);
			pin <= 1'b1;
			repeat (half) @(posedge clk_sys);
			pin <= 1'b0;
			repeat (half - 1) @(posedge clk_sys);
		end
	endtask
endmodule // epc_pulse_src

/* tb/epc_event_pulse_counter_tb.sv */
`timescale 1ns/10ps
module epc_event_pulse_counter_tb
	import epc_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn, ce, wr_en, rd_en, count_direction_pin, cpu_irq_mask, evt, irq_out;
	logic [7:0] addr, wdata, rdata, rv, v1;
	logic [2:0] sub_div = 3'h0;
	int error_cnt = 0;
	int check_count = 0;
	int cyc_cnt = 0;
	// mode, direction pin, preset, count after three pulses
	localparam logic [31:0] ROWS [7] = '{32'h07001013, 32'h4f01100d, 32'h4f001013,
		32'h2f00100d, 32'haf000100, 32'h8f00fdfd, 32'h2f0001fe};
	localparam logic [3:0] SRC [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hd, 4'he,
		4'hb, 4'hc};
	localparam int GAP [11] = '{16384, 4096, 1024, 128, 32, 8, 16384, 4096, 64, 128, 32};
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) sub_div <= sub_div + 3'h1;
	epc_pulse_src src (.clk_sys(clk_sys), .pin(evt));
	epc_event_pulse_counter dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .event_input_pin(evt),
		.count_direction_pin(count_direction_pin), .sub_clk(sub_div[2]),
		.cpu_irq_mask(cpu_irq_mask), .irq_out(irq_out));
	// ==========================================================
	// helpers
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		rv = rdata;
	endtask
	task automatic burst(input int n);
		src.pulses(n, 2);
		repeat (4) @(posedge clk_sys);
	endtask
	// a hang is cut short well past the longest run
	always @(posedge clk_sys)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000)
		begin
			error_cnt++;
			test_done();
		end
	end
	// ==========================================================
	// main sequence
	initial
	begin
		{resetn, wr_en, rd_en, count_direction_pin, addr, wdata} = '0;
		ce = 1'b1;
		cpu_irq_mask = 1'b1;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(ADDR_MODE);
		chk("mode reset", MODE_RESET, rv);
		rd(ADDR_COUNT);
		chk("count reset", COUNT_RESET, rv);
		rd(8'h20);
		chk("unmapped", 8'h00, rv);
		wr(ADDR_MODE, 8'h0f);
		rd(ADDR_MODE);
		chk("mode rw", 8'h1f, rv);
		wr(ADDR_COUNT, 8'h5a);
		burst(3);
		rd(ADDR_COUNT);
		chk("unrouted pin", 8'h5a, rv);
		wr(ADDR_PINSEL, 8'h03);
		rd(ADDR_PINSEL);
		chk("pin select", 8'h03, rv & 8'h03);
		wr(ADDR_IRQ_EN, 8'h01);
		wr(ADDR_COUNT, 8'h00);
		burst(255);
		rd(ADDR_COUNT);
		chk("count 255", 8'hff, rv);
		rd(ADDR_IRQ_STAT);
		chk("no flag yet", 8'h00, rv);
		burst(1);
		rd(ADDR_COUNT);
		chk("wrap", 8'h00, rv);
		rd(ADDR_IRQ_STAT);
		chk("flag", 8'h01, rv);
		chk("irq masked", 8'h00, {7'h0, irq_out});
		@(posedge clk_sys);
		cpu_irq_mask <= 1'b0;
		@(negedge clk_sys);
		chk("irq", 8'h01, {7'h0, irq_out});
		rd(ADDR_IRQ_STAT);
		chk("flag held", 8'h01, rv);
		rd(ADDR_IRQ_EN);
		chk("irq enable", 8'h01, rv);
		wr(ADDR_IRQ_EN, 8'h00);
		@(negedge clk_sys);
		chk("irq disabled", 8'h00, {7'h0, irq_out});
		wr(ADDR_IRQ_CLR, 8'h01);
		wr(ADDR_IRQ_EN, 8'h01);
		rd(ADDR_IRQ_STAT);
		chk("cleared", 8'h00, rv);
		chk("irq cleared", 8'h00, {7'h0, irq_out});
		wr(ADDR_IRQ_STAT, 8'h01);
		rd(ADDR_IRQ_STAT);
		chk("status read-only", 8'h00, rv);
		foreach (ROWS[i])
		begin
			@(posedge clk_sys);
			count_direction_pin <= ROWS[i][16];
			wr(ADDR_MODE, ROWS[i][31:24]);
			wr(ADDR_COUNT, ROWS[i][15:8]);
			burst(3);
			rd(ADDR_COUNT);
			chk("edge mode", ROWS[i][7:0], rv);
		end
		@(posedge clk_sys);
		ce <= 1'b0;
		burst(3);
		@(posedge clk_sys);
		ce <= 1'b1;
		rd(ADDR_COUNT);
		chk("frozen count", 8'hfe, rv);
		wr(ADDR_PINSEL, 8'h00);
		foreach (SRC[i])
		begin
			wr(ADDR_MODE, {4'h0, SRC[i]});
			rd(ADDR_COUNT);
			v1 = rv;
			repeat (GAP[i] - 2) @(posedge clk_sys);
			rd(ADDR_COUNT);
			chk("source rate", 8'h02, rv - v1);
		end
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(ADDR_MODE);
		chk("mode after reset", MODE_RESET, rv);
		rd(ADDR_COUNT);
		chk("count after reset", COUNT_RESET, rv);
		rd(ADDR_PINSEL);
		chk("pin select after reset", 8'h00, rv);
		test_done();
	end
endmodule // epc_event_pulse_counter_tb
